/* File: src/rip_pkg.sv */
// Package for the relay and isolated input register block.
// Assumes a byte-wide host I/O port with a 5-bit offset within the window.
package rip_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned WINDOW_BYTES = 32;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NCH = 8;
  localparam int unsigned CARD_W = 4;

  localparam logic [4:0] OFF_RELAY_BANK = 5'h00;
  localparam logic [4:0] OFF_ISOLATED_INPUTS = 5'h01;
  localparam logic [4:0] OFF_CARD_NUMBER = 5'h02;
  localparam logic [4:0] OFF_IRQ_ENABLE_MASK = 5'h03;
  localparam logic [4:0] OFF_EDGE_SELECT = 5'h04;
  localparam logic [4:0] OFF_IRQ_FLAGS_CLEAR = 5'h05;

  // ----------------------------------------------------------------
  // Reset values and field meaning
  // ----------------------------------------------------------------
  localparam logic [7:0] RELAY_RESET = 8'h00;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] EDGE_RESET = 8'h00;
  localparam logic [7:0] FLAG_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic EDGE_RISING = 1'b0;
  localparam logic EDGE_FALLING = 1'b1;
  // Edges are ignored this many cycles after reset: both sync stages and
  // the previous-level register must hold real pin levels first
  localparam int unsigned SETTLE_CYCLES = 3;

  // Host access strobes for one byte cycle
  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } rip_host_req_t;

endpackage : rip_pkg

/* File: src/rip_sync.sv */
// Two-stage synchroniser for the isolated input levels.
// Assumes inputs arrive asynchronously from the opto-isolators.
`timescale 1ns/10ps
`default_nettype none
module rip_sync (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [rip_pkg::NCH-1:0] async_in,
  output logic [rip_pkg::NCH-1:0] sync_out
);

  typedef struct packed {
    logic [rip_pkg::NCH-1:0] meta;
    logic [rip_pkg::NCH-1:0] sync;
  } rip_sync_state_t;

  rip_sync_state_t state_q;
  rip_sync_state_t state_d;

  // First stage feeds only the second stage
  always_comb begin
    state_d = state_q;
    state_d.meta = async_in;
    state_d.sync = state_q.meta;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign sync_out = state_q.sync;

endmodule : rip_sync
`default_nettype wire

/* File: src/rip_edge_flags.sv */
// Per-channel edge detect and sticky interrupt flags.
// Assumes synchronised input levels on the same clock.
`timescale 1ns/10ps
`default_nettype none
module rip_edge_flags (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [rip_pkg::NCH-1:0] level,
  input wire logic [rip_pkg::NCH-1:0] channel_irq_enable,
  input wire logic [rip_pkg::NCH-1:0] channel_edge_select,
  input wire logic [rip_pkg::NCH-1:0] channel_irq_clear,
  output logic [rip_pkg::NCH-1:0] channel_irq_flag
);

  typedef struct packed {
    logic [rip_pkg::SETTLE_CYCLES-1:0] settle;
    logic [rip_pkg::NCH-1:0] prev;
    logic [rip_pkg::NCH-1:0] flag;
  } rip_flag_state_t;

  rip_flag_state_t state_q;
  rip_flag_state_t state_d;
  logic [rip_pkg::NCH-1:0] hit;

  // ----------------------------------------------------------------
  // Edge detection per channel
  // ----------------------------------------------------------------
  // Sync stages and prev reset to 0, so a pin that is high at reset would
  // look like a rising edge; hold detection off until they settle
  genvar g;
  generate
    for (g = 0; g < rip_pkg::NCH; g++) begin : g_ch
      assign hit[g] = state_q.settle[rip_pkg::SETTLE_CYCLES-1] && // R13
        channel_irq_enable[g] && // R13
        ((channel_edge_select[g] == rip_pkg::EDGE_RISING) ? // R8
          (level[g] && !state_q.prev[g]) :
          (!level[g] && state_q.prev[g]));
    end
  endgenerate

  // Set wins over a clear in the same cycle
  always_comb begin
    state_d = state_q;
    state_d.settle = {state_q.settle[rip_pkg::SETTLE_CYCLES-2:0], 1'b1};
    state_d.prev = level;
    state_d.flag = (state_q.flag & ~channel_irq_clear) | hit; // R9 R10
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign channel_irq_flag = state_q.flag;

endmodule : rip_edge_flags
`default_nettype wire

/* File: src/rip_regs.sv */
// Host-visible byte register block for relay outputs and isolated inputs.
// Assumes the host decode supplies a 5-bit offset within a 32-byte window
// with single-cycle read and write strobes on clk.
//
// Contract
// R1 - Decode 32-byte I/O window, fixed offsets
// R2 - Write offset 0 latches relay drive bits
// R3 - Read offset 0 returns relay latches
// R4 - Reset clears all relay latches
// R5 - Offset 1 reads inputs, writes ignored
// R6 - Offset 2 reads 4-bit card number
// R7 - Offset 3 holds interrupt enable bits
// R8 - Offset 4 edge select, 0 rising
// R9 - Offset 5 reads interrupt flags
// R10 - Writing 1 at offset 5 clears flag
// R11 - Software clears flag after servicing
// R12 - Drive bit 1 selects normally-open contact
// R13 - Sync inputs, gate by enable, raise irq
`timescale 1ns/10ps
`default_nettype none
module rip_regs (
  input wire logic clk,
  input wire logic nrst,
  input wire rip_pkg::rip_host_req_t host_req,
  output logic [rip_pkg::DATA_W-1:0] host_rdata,
  input wire logic [rip_pkg::NCH-1:0] isolated_input_bit,
  input wire logic [rip_pkg::CARD_W-1:0] card_number_bit,
  output logic [rip_pkg::NCH-1:0] relay_drive_bit,
  output logic host_irq
);

  typedef struct packed {
    logic [rip_pkg::NCH-1:0] relay;
    logic [rip_pkg::NCH-1:0] enable;
    logic [rip_pkg::NCH-1:0] edge_sel;
    logic [rip_pkg::CARD_W-1:0] card_meta;
    logic [rip_pkg::CARD_W-1:0] card;
    logic [rip_pkg::DATA_W-1:0] rdata;
    logic irq;
  } rip_regs_state_t;

  rip_regs_state_t state_q;
  rip_regs_state_t state_d;
  logic [rip_pkg::NCH-1:0] inputs_sync;
  logic [rip_pkg::NCH-1:0] flags;
  logic [rip_pkg::NCH-1:0] clear_bits;
  logic wr_flags;

  // ----------------------------------------------------------------
  // Input conditioning and event flags
  // ----------------------------------------------------------------
  rip_sync u_sync (
    .clk(clk),
    .nrst(nrst),
    .async_in(isolated_input_bit),
    .sync_out(inputs_sync)
  );

  assign wr_flags = host_req.wr &&
    (host_req.addr == rip_pkg::OFF_IRQ_FLAGS_CLEAR);
  assign clear_bits = wr_flags ? host_req.wdata : '0; // R10

  rip_edge_flags u_flags (
    .clk(clk),
    .nrst(nrst),
    .level(inputs_sync),
    .channel_irq_enable(state_q.enable),
    .channel_edge_select(state_q.edge_sel),
    .channel_irq_clear(clear_bits),
    .channel_irq_flag(flags)
  );

  // ----------------------------------------------------------------
  // Register writes and read mux
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    // Card switches are static straps but still synchronised
    state_d.card_meta = card_number_bit;
    state_d.card = state_q.card_meta;
    // A flag stays set until software clears it; no re-trigger needed
    state_d.irq = |flags; // R13 R11
    if (host_req.wr) begin
      case (host_req.addr) // R1
        rip_pkg::OFF_RELAY_BANK: state_d.relay = host_req.wdata; // R2 R12
        rip_pkg::OFF_IRQ_ENABLE_MASK: state_d.enable = host_req.wdata; // R7
        rip_pkg::OFF_EDGE_SELECT: state_d.edge_sel = host_req.wdata; // R8
        // Offsets 1 and 2 and unused offsets ignore writes
        default: state_d.relay = state_q.relay; // R5 R6
      endcase
    end
    state_d.rdata = rip_pkg::READ_ZERO;
    if (host_req.rd) begin
      case (host_req.addr) // R1
        rip_pkg::OFF_RELAY_BANK: state_d.rdata = state_q.relay; // R3
        rip_pkg::OFF_ISOLATED_INPUTS: state_d.rdata = inputs_sync; // R5
        rip_pkg::OFF_CARD_NUMBER: begin
          state_d.rdata = {{(rip_pkg::DATA_W - rip_pkg::CARD_W){1'b0}},
            state_q.card}; // R6
        end
        rip_pkg::OFF_IRQ_ENABLE_MASK: state_d.rdata = state_q.enable; // R7
        rip_pkg::OFF_EDGE_SELECT: state_d.rdata = state_q.edge_sel; // R8
        rip_pkg::OFF_IRQ_FLAGS_CLEAR: state_d.rdata = flags; // R9
        default: state_d.rdata = rip_pkg::READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q.relay <= rip_pkg::RELAY_RESET; // R4
      state_q.enable <= rip_pkg::ENABLE_RESET;
      state_q.edge_sel <= rip_pkg::EDGE_RESET;
      state_q.card_meta <= '0;
      state_q.card <= '0;
      state_q.rdata <= rip_pkg::READ_ZERO;
      state_q.irq <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  assign relay_drive_bit = state_q.relay; // R12
  assign host_rdata = state_q.rdata;
  assign host_irq = state_q.irq;

endmodule : rip_regs
`default_nettype wire

/* File: tb/rip_host.sv */
// Host processor model: byte reads and writes on the register port.
// Assumes requests change at the falling edge of clk.
`timescale 1ns/10ps
`default_nettype none
module rip_host (
  input wire logic clk,
  input wire logic [7:0] host_rdata,
  output var rip_pkg::rip_host_req_t host_req
);
  initial host_req = '0;
  // Released lines show the inverse, never a stale copy
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk);
    host_req = '{1'b0, 1'b1, a, d};
    @(negedge clk);
    host_req = '{1'b0, 1'b0, ~a, ~d};
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(negedge clk);
    host_req = '{1'b1, 1'b0, a, 8'h00};
    @(negedge clk);
    d = host_rdata;
    host_req = '{1'b0, 1'b0, ~a, 8'hff};
  endtask : rd
endmodule : rip_host
`default_nettype wire

/* File: tb/rip_regs_assertions.sv */
// Checker on the ports of the register block.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module rip_chk (
  input wire logic clk,
  input wire logic nrst,
  input wire rip_pkg::rip_host_req_t host_req,
  input wire logic [7:0] host_rdata,
  input wire logic [7:0] isolated_input_bit,
  input wire logic [3:0] card_number_bit,
  input wire logic [7:0] relay_drive_bit,
  input wire logic host_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  wire logic rd = host_req.rd;
  wire logic wr = host_req.wr;
  wire logic [4:0] ad = host_req.addr;
  wire logic [7:0] wd = host_req.wdata;
  property p_wr0; wr && ad == 5'h00 |=> relay_drive_bit == $past(wd);
  endproperty
  a_wr0: assert property (p_wr0) else $error("relay write lost");
  property p_rst; disable iff (1'b0) !nrst |=> relay_drive_bit == 8'h00
    && !host_irq && host_rdata == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("reset value");
  property p_rd0; rd && ad == 5'h00 |=> host_rdata == $past(relay_drive_bit);
  endproperty
  a_rd0: assert property (p_rd0) else $error("relay readback");
  property p_card; rd && ad == 5'h02 |=> host_rdata[7:4] == 4'h0;
  endproperty
  a_card: assert property (p_card) else $error("card high bits");
  property p_card_val; rd && ad == 5'h02 && $past(nrst) && $past(nrst, 2)
    |=> host_rdata == {4'h0, $past(card_number_bit, 3)}; endproperty
  a_card_val: assert property (p_card_val) else $error("card value");
  property p_in; rd && ad == 5'h01 && $past(nrst) && $past(nrst, 2)
    |=> host_rdata == $past(isolated_input_bit, 3); endproperty
  a_in: assert property (p_in) else $error("input level");
  property p_zero; !rd || ad > 5'h05 |=> host_rdata == 8'h00; endproperty
  a_zero: assert property (p_zero) else $error("idle read data");
  property p_ctl; wr && (ad == 5'h03 || ad == 5'h04) ##1 !wr ##1
    rd && ad == $past(ad, 2) |=> host_rdata == $past(wd, 3); endproperty
  a_ctl: assert property (p_ctl) else $error("control readback");
  property p_irq; rd && ad == 5'h05 |=> host_irq == (host_rdata != 8'h00);
  endproperty
  a_irq: assert property (p_irq) else $error("irq vs flags");
  property p_fall; $fell(host_irq) && $past(nrst) |->
    $past(wr && ad == 5'h05, 2); endproperty
  a_fall: assert property (p_fall) else $error("irq drop");
endmodule : rip_chk
bind rip_regs rip_chk rip_chk_inst (.clk(clk), .nrst(nrst),
  .host_req(host_req), .host_rdata(host_rdata),
  .isolated_input_bit(isolated_input_bit),
  .card_number_bit(card_number_bit),
  .relay_drive_bit(relay_drive_bit), .host_irq(host_irq));
`default_nettype wire

/* File: tb/tb_relay_input_irq_port.sv */
// Self-checking bench for the relay and isolated input block.
// Assumes the host model drives accesses at the falling edge.
`timescale 1ns/10ps
`default_nettype none
module tb_relay_input_irq_port;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] din = 8'h00;
  logic [3:0] card = 4'h9;
  logic [7:0] v, rdata, relay;
  logic irq;
  rip_pkg::rip_host_req_t req;
  int miscompares = 0;
  int checked = 0;
  initial forever #5 clk = ~clk;
  rip_regs rip_regs_inst (.clk(clk), .nrst(nrst), .host_req(req),
    .host_rdata(rdata), .isolated_input_bit(din),
    .card_number_bit(card), .relay_drive_bit(relay), .host_irq(irq));
  rip_host rip_host_inst (.clk(clk), .host_rdata(rdata), .host_req(req));
  task automatic chk(input logic [7:0] s, e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    rip_host_inst.wr(a, d);
  endtask : wr
  task automatic rchk(input logic [4:0] a, input logic [7:0] e);
    rip_host_inst.rd(a, v);
    chk(v, e);
  endtask : rchk
  task automatic t_relay();
    rchk(5'h00, 8'h00);
    wr(5'h00, 8'ha5);
    chk(relay, 8'ha5);
    wr(5'h01, 8'hff);
    wr(5'h02, 8'hff);
    rchk(5'h00, 8'ha5);
    nrst = 1'b0;
    @(negedge clk);
    nrst = 1'b1;
    chk(relay, 8'h00);
  endtask : t_relay
  task automatic t_inputs();
    din = 8'h3c;
    repeat (4) @(negedge clk);
    rchk(5'h01, 8'h3c);
    rchk(5'h02, {4'h0, card});
    rchk(5'h06, 8'h00);
    rchk(5'h1f, 8'h00);
  endtask : t_inputs
  // Only the low four channels are enabled, so the upper flags stay low
  task automatic t_irq(input logic fall);
    din = {8{fall}};
    repeat (4) @(negedge clk);
    wr(5'h03, 8'h0f);
    wr(5'h04, {8{fall}});
    rchk(5'h04, {8{fall}});
    wr(5'h05, 8'hff);
    rchk(5'h05, 8'h00);
    din = ~din;
    repeat (5) @(negedge clk);
    rchk(5'h05, 8'h0f);
    chk({7'h00, irq}, 8'h01);
    wr(5'h05, 8'h03);
    rchk(5'h05, 8'h0c);
    wr(5'h05, 8'h0c);
    @(negedge clk);
    chk({7'h00, irq}, 8'h00);
    din = ~din;
    repeat (5) @(negedge clk);
    rchk(5'h05, 8'h00);
  endtask : t_irq
  task automatic report_and_stop();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    t_relay();
    t_inputs();
    t_irq(1'b0);
    t_irq(1'b1);
    report_and_stop();
  end
  initial begin
    #100000;
    miscompares++;
    report_and_stop();
  end
endmodule : tb_relay_input_irq_port
`default_nettype wire
